/* File: hw/pfhc_host.sv */
// Host controller that drives a parallel NOR flash through its bus pins.
module pfhc_host
	import pfhc_pkg::*;
(
	input  wire logic             MCLK,
	input  wire logic             RESET_N,
	// Command port.
	input  wire pfhc_pkg::pfhc_req_t REQ,
	output logic                  REQ_READY,
	output pfhc_pkg::pfhc_rsp_t   RSP,
	// Flash pins.
	output pfhc_pkg::pfhc_pins_t  PINS,
	input  wire logic [15:0]      DQ_IN,
	input  wire logic             READY_BUSY_N
);
	import pfhc_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE,
		S_READ,
		S_WSETUP,
		S_WPULSE,
		S_WRECOV,
		S_RPULSE,
		S_RWAIT
	} pfhc_state_t;

	typedef struct packed {
		pfhc_state_t state;
		logic [CNT_W-1:0] cnt;
		pfhc_pins_t  pins;
		pfhc_rsp_t   rsp;
	} pfhc_st_t;

	pfhc_st_t st_q;
	pfhc_st_t st_d;

	assign REQ_READY = (st_q.state == S_IDLE);
	assign PINS      = st_q.pins;
	assign RSP       = st_q.rsp;

	always_comb begin
		st_d           = st_q;
		st_d.rsp.valid = 1'b0;
		unique case (st_q.state)
			S_IDLE: begin
				// Parked pins leave the device in standby with its outputs floating.
				st_d.pins.chip_sel_n     = 1'b1;
				st_d.pins.out_gate_n     = 1'b1;
				st_d.pins.write_strobe_n = 1'b1;
				st_d.pins.dq_oe          = 16'h0000;
				if (REQ.valid) begin
					st_d.pins.addr      = REQ.addr;
					st_d.pins.byte_sel_n = ~REQ.byte_mode;
					if (REQ.byte_mode) begin
						// The top data pin carries the byte address bit in byte mode.
						st_d.pins.dq_out = {REQ.byte_lsb, 7'h00, REQ.wdata[7:0]};
						st_d.pins.dq_oe  = 16'h8000;
					end else begin
						st_d.pins.dq_out = REQ.wdata;
					end
					unique case (REQ.op)
						PFHC_OP_READ: begin
							// Select and gate low, strobe high; no command precedes.
							st_d.pins.chip_sel_n = 1'b0;
							st_d.pins.out_gate_n = 1'b0;
							// Worst of select and address access covers standby exit.
							st_d.cnt   = CNT_W'(SELECT_CYC > ACCESS_CYC ? SELECT_CYC : ACCESS_CYC);
							st_d.state = S_READ;
						end
						PFHC_OP_WRITE: begin
							// Gate stays high during writes.
							st_d.pins.chip_sel_n = 1'b0;
							st_d.cnt   = CNT_W'(1);
							st_d.state = S_WSETUP;
						end
						PFHC_OP_RESET: begin
							st_d.pins.reset_n = 1'b0;
							st_d.cnt   = CNT_W'(RPULSE_CYC);
							st_d.state = S_RPULSE;
						end
						default: st_d.state = S_IDLE;
					endcase
				end
			end
			S_READ: begin
				// Array, identifier and status reads all share this timing.
				st_d.cnt = st_q.cnt - CNT_W'(1);
				if (st_q.cnt == CNT_W'(1)) begin
					st_d.rsp.valid = 1'b1;
					st_d.rsp.rdata = st_q.pins.byte_sel_n ? DQ_IN : {8'h00, DQ_IN[7:0]};
					st_d.state     = S_IDLE;
				end
			end
			S_WSETUP: begin
				// Address is set before the strobe falls; data is driven.
				if (st_q.pins.byte_sel_n)
					st_d.pins.dq_oe = 16'hFFFF;
				else
					st_d.pins.dq_oe = 16'h80FF;
				st_d.pins.write_strobe_n = 1'b0;
				st_d.cnt   = CNT_W'(WPULSE_CYC);
				st_d.state = S_WPULSE;
			end
			S_WPULSE: begin
				st_d.cnt = st_q.cnt - CNT_W'(1);
				if (st_q.cnt == CNT_W'(1)) begin
					// Strobe rises first, so data is latched while still held.
					st_d.pins.write_strobe_n = 1'b1;
					st_d.cnt   = CNT_W'(WRECOV_CYC);
					st_d.state = S_WRECOV;
				end
			end
			S_WRECOV: begin
				st_d.pins.chip_sel_n = 1'b1;
				st_d.cnt = st_q.cnt - CNT_W'(1);
				if (st_q.cnt == CNT_W'(1)) begin
					st_d.pins.dq_oe = 16'h0000;
					st_d.state      = S_IDLE;
				end
			end
			S_RPULSE: begin
				st_d.cnt = st_q.cnt - CNT_W'(1);
				if (st_q.cnt == CNT_W'(1)) begin
					st_d.pins.reset_n = 1'b1;
					st_d.cnt   = CNT_W'(RREAD_CYC);
					st_d.state = S_RWAIT;
				end
			end
			S_RWAIT: begin
				// Also wait for ready, since a cut operation holds busy low.
				if (st_q.cnt != CNT_W'(0))
					st_d.cnt = st_q.cnt - CNT_W'(1);
				else if (READY_BUSY_N)
					st_d.state = S_IDLE; // Software reissues cut operations.
			end
			default: st_d.state = S_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			st_q.state               <= S_IDLE;
			st_q.cnt                 <= '0;
			st_q.pins.chip_sel_n     <= 1'b1;
			st_q.pins.out_gate_n     <= 1'b1;
			st_q.pins.write_strobe_n <= 1'b1;
			st_q.pins.reset_n        <= 1'b1;
			st_q.pins.byte_sel_n     <= 1'b1;
			st_q.pins.addr           <= ADDR_RESET;
			st_q.pins.dq_out         <= DATA_RESET;
			st_q.pins.dq_oe          <= 16'h0000;
			st_q.rsp                 <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	a_read_strobe_high: assert property (@(posedge MCLK) disable iff (!RESET_N)
		!st_q.pins.out_gate_n |-> st_q.pins.write_strobe_n)
		else $error("write strobe low while gate low");
	a_write_gate_high: assert property (@(posedge MCLK) disable iff (!RESET_N)
		!st_q.pins.write_strobe_n |-> st_q.pins.out_gate_n && !st_q.pins.chip_sel_n)
		else $error("write without select or with gate low");
	a_read_select: assert property (@(posedge MCLK) disable iff (!RESET_N)
		st_q.state == S_READ |-> !st_q.pins.chip_sel_n && !st_q.pins.out_gate_n)
		else $error("read without select and gate");
	a_reset_pulse_len: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$fell(st_q.pins.reset_n) |-> !st_q.pins.reset_n [*8])
		else $error("reset pulse too short");
	a_reset_wait_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(st_q.pins.reset_n) |-> !REQ_READY [*8])
		else $error("request taken before reset-to-read delay");
	a_rsp_after_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		RSP.valid |-> $past(st_q.state) == S_READ)
		else $error("response without read");
	a_write_data_held: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(st_q.pins.write_strobe_n) |-> st_q.pins.dq_oe[0] && !st_q.pins.chip_sel_n)
		else $error("data or select dropped at strobe rise");
	a_byte_top_pin: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(!st_q.pins.byte_sel_n && st_q.state == S_WPULSE) |-> st_q.pins.dq_oe == 16'h80FF)
		else $error("wrong byte mode drive");

	// The strobe stays low for the full write pulse, nine cycles at the current clock.
	sequence s_strobe_low_run;
		(!st_q.pins.write_strobe_n) [*8] ##1 !st_q.pins.write_strobe_n;
	endsequence
	// Select is still low when the strobe rises, so the later rise never cuts the data.
	sequence s_strobe_release;
		st_q.pins.write_strobe_n && !st_q.pins.chip_sel_n;
	endsequence
	a_write_pulse_len: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$fell(st_q.pins.write_strobe_n) |-> s_strobe_low_run ##1 s_strobe_release)
		else $error("write strobe pulse length wrong");
	a_busy_holds_wait: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(st_q.state == S_RWAIT && !READY_BUSY_N) |=> !REQ_READY)
		else $error("request accepted while flash still busy after reset");
endmodule

/* File: hw/pfhc_pkg.sv */
// Package of timing constants, types and pin groups for the parallel flash host controller.
package pfhc_pkg;
	localparam int CLK_PERIOD_NS        = 5;
	localparam int ADDRESS_ACCESS_NS    = 90;
	localparam int SELECT_ACCESS_NS     = 90;
	localparam int WRITE_PULSE_NS       = 45;
	localparam int WRITE_RECOVER_NS     = 30;
	localparam int RESET_PULSE_MIN_NS   = 500;
	localparam int RESET_TO_READ_NS     = 200;
	localparam int ACCESS_CYC    = (ADDRESS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECT_CYC    = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRECOV_CYC    = (WRITE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RPULSE_CYC    = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RREAD_CYC     = (RESET_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 8;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [18:0] ADDR_RESET = 19'h0_0000;

	typedef enum logic [1:0] {
		PFHC_OP_READ,
		PFHC_OP_WRITE,
		PFHC_OP_RESET
	} pfhc_op_t;

	typedef struct packed {
		logic        valid;
		pfhc_op_t    op;
		logic        byte_mode;
		logic [18:0] addr;
		logic        byte_lsb;
		logic [15:0] wdata;
	} pfhc_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] rdata;
	} pfhc_rsp_t;

	typedef struct packed {
		logic        chip_sel_n;
		logic        out_gate_n;
		logic        write_strobe_n;
		logic        reset_n;
		logic        byte_sel_n;
		logic [18:0] addr;
		logic [15:0] dq_out;
		logic [15:0] dq_oe;
	} pfhc_pins_t;
endpackage

/* File: verification/pfhc_flash_model.sv */
// Behavioural model of the flash device seen through the host controller pins.
module pfhc_flash_model (
	// Clock and pins.
	input  wire logic                 clk,
	input  wire pfhc_pkg::pfhc_pins_t pins,
	input  wire logic [15:0]          dq,
	// Device outputs.
	output logic [15:0]               dq_out,
	output logic                      ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import pfhc_pkg::*;
	logic [15:0] mem [16];
	// Holds the output word of the previous clock, so a released bus toggles every cycle.
	logic [15:0] last = 16'h0000;
	logic [18:0] wa;
	int          busy = 0;
	wire         wr_n = pins.chip_sel_n | pins.write_strobe_n | !pins.reset_n;
	wire         rd = !pins.chip_sel_n && !pins.out_gate_n && pins.reset_n;
	wire  [15:0] word = mem[pins.addr[3:0]];
	wire  [7:0]  half = dq[15] ? word[15:8] : word[7:0];
	wire  [15:0] val = pins.byte_sel_n ? word : {~last[15:8], half};
	// Identifier, status and erase cycles are plain reads and writes at these pins.
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	always @(negedge wr_n) wa = pins.addr;
	always @(posedge wr_n) begin
		if (pins.byte_sel_n) mem[wa[3:0]] = dq;
		else if (dq[15]) mem[wa[3:0]][15:8] = dq[7:0];
		else mem[wa[3:0]][7:0] = dq[7:0];
		busy <= 30;
	end
	// Busy is held long after reset so that the host must really wait for ready.
	always @(posedge clk) begin
		if (!pins.reset_n) busy <= 60;
		else if (busy > 0) busy <= busy - 1;
		last <= dq_out;
	end
	assign ready_busy_n = (busy == 0) && pins.reset_n;
	// A released bus shows a changing pattern so that a stale value never matches.
	assign dq_out = rd ? val : ~last;
endmodule

/* File: verification/pfhc_host_bench.sv */
// Self-checking testbench for the parallel flash host controller.
module pfhc_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pfhc_pkg::*;
	logic        mclk = 0;
	logic        reset_n = 0;
	pfhc_req_t   req = '0;
	logic        ready;
	logic        rb;
	pfhc_rsp_t   rsp;
	pfhc_pins_t  pins;
	logic [15:0] fdq;
	logic [15:0] dq;
	logic [18:0] a;
	logic [15:0] d;
	int          miscompares = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          n;
	int          rlow = 0;
	int          mem [16];
	always #2.5 mclk = ~mclk;
	assign dq = (pins.dq_oe & pins.dq_out) | (~pins.dq_oe & fdq);
	pfhc_host dut (.MCLK(mclk), .RESET_N(reset_n), .REQ(req), .REQ_READY(ready), .RSP(rsp),
		.PINS(pins), .DQ_IN(dq), .READY_BUSY_N(rb));
	pfhc_flash_model flash (.clk(mclk), .pins(pins), .dq(dq), .dq_out(fdq), .ready_busy_n(rb));
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(negedge mclk) begin
		cyc++;
		if (pins.out_gate_n === 1'b0) check("strobe in read", pins.write_strobe_n, 1);
		if (pins.write_strobe_n === 1'b0) check("gate in write", pins.out_gate_n, 1);
		if (pins.reset_n === 1'b0) begin
			rlow++;
		end else if (rlow != 0) begin
			check("reset pulse", rlow, RPULSE_CYC);
			rlow = 0;
		end
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	// Holds the request from a falling edge until the edge that takes it.
	task automatic run(pfhc_op_t op, logic bm, logic [18:0] ad, logic lsb, logic [15:0] wd);
		@(negedge mclk);
		req = '{1'b1, op, bm, ad, lsb, wd};
		do @(posedge mclk); while (ready !== 1'b1);
		n = 0;
		do begin
			@(negedge mclk);
			req.valid = 1'b0;
			n++;
			if (n == 1) begin
				check("address pins", pins.addr, ad);
				check("width select", pins.byte_sel_n, !bm);
			end
		end while (op == PFHC_OP_READ ? rsp.valid !== 1'b1 : ready !== 1'b1);
	endtask
	task automatic rd(logic bm, logic [18:0] ad, logic lsb);
		int e;
		e = mem[ad[3:0]];
		run(PFHC_OP_READ, bm, ad, lsb, 16'h0000);
		check("read latency", n, 19);
		check("read data", rsp.rdata, bm ? (lsb ? e[15:8] : e[7:0]) : e[15:0]);
	endtask
	task automatic wr(logic bm, logic [18:0] ad, logic lsb, logic [15:0] wd);
		run(PFHC_OP_WRITE, bm, ad, lsb, wd);
		check("write latency", n, 17);
		if (!bm) mem[ad[3:0]] = wd;
		else if (lsb) mem[ad[3:0]][15:8] = wd[7:0];
		else mem[ad[3:0]][7:0] = wd[7:0];
	endtask
	initial begin
		foreach (mem[i]) mem[i] = 32'h0000_FFFF;
		repeat (6) @(negedge mclk);
		reset_n = 1'b1;
		void'($urandom(93));
		rd(1'b0, 19'h0_0003, 1'b0);
		repeat (6) begin
			a = 19'($urandom);
			d = 16'($urandom);
			wr(1'b0, a, 1'b0, d);
			rd(1'b0, a, 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			wr(1'b1, a, i[0], d + 16'(i));
			rd(1'b1, a, i[0]);
		end
		rd(1'b0, a, 1'b0);
		wr(1'b0, a, 1'b0, ~d);
		run(PFHC_OP_RESET, 1'b0, a, 1'b0, 16'h0000);
		check("reset wait", n > 160, 1);
		check("reset to read", n > RPULSE_CYC + RREAD_CYC, 1);
		rd(1'b0, a, 1'b0);
		end_of_test();
	end
endmodule
